// ### src/mxio_pkg.sv
package mxio_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  // debounce: active level must persist longer than 3 ms
  localparam int unsigned DEBOUNCE_MS = 3;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  // step clock ceiling 78 kHz; minimum period rounds up
  localparam int unsigned STEP_MAX_HZ = 78_000;
  localparam int unsigned STEP_MIN_CYC = (CLK_HZ + STEP_MAX_HZ - 1) / STEP_MAX_HZ;
  localparam int unsigned STEP_HIGH_CYC = STEP_MIN_CYC / 2;

  // register offsets
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;

  // cfg field positions
  localparam int unsigned CFG_OUT_MODE = 0;
  localparam int unsigned CFG_INVERT = 1;
  localparam int unsigned CFG_ACT_LSB = 2;
  localparam int unsigned CFG_OSEL_LSB = 5;
  localparam int unsigned CFG_EXT_DRV = 7;
  localparam int unsigned CFG_INPUT_EN = 8;
  localparam logic [8:0] CFG_RESET = 9'h000;

  // status field positions
  localparam int unsigned ST_LINE = 0;
  localparam int unsigned ST_ALARM = 1;
  localparam int unsigned ST_EXT = 2;

  // interrupt bits
  localparam int unsigned IRQ_TRIG = 0;
  localparam int unsigned IRQ_ALARM = 1;
  localparam int unsigned IRQ_W = 2;

  typedef enum logic [2:0] {
    ACT_STOP = 3'h0,
    ACT_POWER_OFF = 3'h1,
    ACT_SHIFT = 3'h2,
    ACT_HOME = 3'h3,
    ACT_ALARM = 3'h4
  } mxio_action_t;

  typedef enum logic [1:0] {
    OSEL_MOVING = 2'h0,
    OSEL_ALARM = 2'h1,
    OSEL_WIND = 2'h2,
    OSEL_PRESENT = 2'h3
  } mxio_osel_t;

  typedef struct packed {
    logic stop;
    logic windingPowerOff;
    logic relativeShift;
    logic home;
  } mxio_cmd_t;

  typedef struct packed {
    logic moving;
    logic windingsPowered;
    logic motorPresent;
  } mxio_motion_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mxio_bus_req_t;

endpackage

// ### src/mxio_aux_io.sv
// Notes on behaviour
// R1: line set as input or output
// R2: high active by default, invert flips
// R3: input mode reports logical line state
// R4: activation launches one selected action
// R5: alarm action kills bridge, latches until reinit
// R6: invert change can also cause activation
// R7: action only after active over 3 ms
// R8: active at power-up also triggers
// R9: output mode shows selected event
// R10: driver uses enable, direction, step clock
// R11: direction high right, low left
// R12: one pulse per microstep displacement
// R13: step rate never above 78 kHz
// R14: driver mode takes over shared pin
// R15: external driver uses same step division
// R16: debounce restarts when input leaves active
// R17: enable only in driver mode, windings on
`timescale 1ns/100ps
module mxio_aux_io
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire mxio_pkg::mxio_bus_req_t busReq,
  output logic [31:0] busRdata,
  output logic irq,
  // motion core
  input wire mxio_pkg::mxio_motion_t motion,
  input wire logic reinit,
  input wire logic stepReq,
  input wire logic stepDirRight,
  output logic stepAccept,
  output mxio_pkg::mxio_cmd_t actionCmd,
  output logic alarmActive,
  output logic bridgeEnable,
  // shared pin and driver outputs
  input wire logic ioLineIn,
  output logic ioLineOut,
  output logic ioLineOe,
  output logic drvEnable,
  output logic drvDirection
);
  import mxio_pkg::*;

  logic [8:0] cfg_q;
  logic [IRQ_W-1:0] irqStat_q, irqMask_q;
  logic syncA_q, syncB_q;
  logic [23:0] dbCnt_q;
  logic qualified_q, armed_q;
  logic alarm_q;
  logic [7:0] stepCnt_q;
  logic stepOut_q, dir_q;
  logic [31:0] rdata_q;
  mxio_cmd_t cmd_q;
  logic lineActive, trigger, isOut, extMode;
  mxio_action_t act;
  mxio_osel_t osel;
  logic eventLevel;

  assign isOut = cfg_q[CFG_OUT_MODE]; // R1
  assign extMode = cfg_q[CFG_EXT_DRV];
  assign act = mxio_action_t'(cfg_q[CFG_ACT_LSB +: 3]);
  assign osel = mxio_osel_t'(cfg_q[CFG_OSEL_LSB +: 2]);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfg_q <= CFG_RESET;
    else if (busReq.wr && busReq.addr == REG_CFG)
      cfg_q <= busReq.wdata[8:0];
  end

  // two-stage synchroniser on the pin
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end
    else
    begin
      syncA_q <= ioLineIn;
      syncB_q <= syncA_q;
    end
  end

  // invert is applied after sync, so toggling it also makes the line active
  assign lineActive = (syncB_q ^ cfg_q[CFG_INVERT]) && !isOut && !extMode; // R2 R6

  // counter runs from zero after every drop; armed_q starts high so a line
  // already active out of reset still qualifies once
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dbCnt_q <= 24'h000000;
      qualified_q <= 1'b0;
    end
    else if (!lineActive)
    begin
      dbCnt_q <= 24'h000000; // R16
      qualified_q <= 1'b0;
    end
    else if (dbCnt_q < 24'(DEBOUNCE_CYC))
      dbCnt_q <= dbCnt_q + 24'h000001;
    else
      qualified_q <= 1'b1; // R7
  end

  assign trigger = qualified_q && armed_q && cfg_q[CFG_INPUT_EN];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      armed_q <= 1'b1; // R8
    else if (!lineActive)
      armed_q <= 1'b1;
    else if (trigger)
      armed_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cmd_q <= '0;
    else
    begin
      cmd_q.stop <= trigger && act == ACT_STOP; // R4
      cmd_q.windingPowerOff <= trigger && act == ACT_POWER_OFF;
      cmd_q.relativeShift <= trigger && act == ACT_SHIFT;
      cmd_q.home <= trigger && act == ACT_HOME;
    end
  end
  assign actionCmd = cmd_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      alarm_q <= 1'b0;
    else if (trigger && act == ACT_ALARM)
      alarm_q <= 1'b1; // R5
    else if (reinit)
      alarm_q <= 1'b0;
  end
  assign alarmActive = alarm_q;
  assign bridgeEnable = !alarm_q && !extMode; // R5

  always_comb
  begin
    unique case (osel) // R9
      OSEL_MOVING: eventLevel = motion.moving;
      OSEL_ALARM: eventLevel = alarm_q;
      OSEL_WIND: eventLevel = motion.windingsPowered;
      OSEL_PRESENT: eventLevel = motion.motorPresent;
    endcase
  end

  // step clock: one pulse per accepted request, spaced at least STEP_MIN_CYC
  assign stepAccept = extMode && stepReq && stepCnt_q == 8'h00; // R13

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stepCnt_q <= 8'h00;
      stepOut_q <= 1'b0;
      dir_q <= 1'b0;
    end
    else if (stepAccept)
    begin
      stepCnt_q <= 8'(STEP_MIN_CYC - 1); // R12
      stepOut_q <= 1'b1;
      dir_q <= stepDirRight; // R11
    end
    else
    begin
      if (stepCnt_q != 8'h00)
        stepCnt_q <= stepCnt_q - 8'h01;
      if (stepCnt_q <= 8'(STEP_MIN_CYC - STEP_HIGH_CYC))
        stepOut_q <= 1'b0;
    end
  end

  // cycles since the last accepted step, saturating at the minimum period;
  // checks the spacing independently of the down-counter that enforces it
  logic [7:0] sinceStep_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sinceStep_q <= 8'(STEP_MIN_CYC);
    else if (stepAccept)
      sinceStep_q <= 8'h01;
    else if (sinceStep_q < 8'(STEP_MIN_CYC))
      sinceStep_q <= sinceStep_q + 8'h01;
  end

  // pin ownership: driver step clock wins, else output mode event level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ioLineOut <= 1'b0;
      ioLineOe <= 1'b0;
      drvEnable <= 1'b0;
      drvDirection <= 1'b0;
    end
    else
    begin
      ioLineOe <= extMode || isOut; // R1 R14
      ioLineOut <= extMode ? stepOut_q : (eventLevel ^ cfg_q[CFG_INVERT]); // R10 R14
      drvEnable <= extMode && motion.windingsPowered && !alarm_q; // R17
      drvDirection <= dir_q; // R11
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqMask_q <= '0;
    else if (busReq.wr && busReq.addr == REG_IRQ_MASK)
      irqMask_q <= busReq.wdata[IRQ_W-1:0];
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqStat_q <= '0;
    else
    begin
      for (int i = 0; i < IRQ_W; i++)
      begin
        if ((i == IRQ_TRIG && trigger) || (i == IRQ_ALARM && trigger && act == ACT_ALARM))
          irqStat_q[i] <= 1'b1;
        else if (busReq.wr && busReq.addr == REG_IRQ_STAT && busReq.wdata[i])
          irqStat_q[i] <= 1'b0;
      end
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_q <= 32'h00000000;
    else if (busReq.rd)
    begin
      unique case (busReq.addr)
        REG_CFG: rdata_q <= {23'h000000, cfg_q};
        REG_STATUS: rdata_q <= {29'h00000000, extMode, alarm_q, // R3
          isOut ? ioLineOut : (syncB_q ^ cfg_q[CFG_INVERT])};
        REG_IRQ_STAT: rdata_q <= {30'h00000000, irqStat_q};
        REG_IRQ_MASK: rdata_q <= {30'h00000000, irqMask_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
    else
      rdata_q <= 32'h00000000;
  end
  assign busRdata = rdata_q;

  a_alarm_latch: assert property (@(posedge clk) disable iff (sys_rst) // R5
    alarm_q && !reinit |=> alarm_q && !bridgeEnable)
    else $error("alarm dropped without reinit");
  a_debounce_time: assert property (@(posedge clk) disable iff (sys_rst) // R7
    qualified_q |-> dbCnt_q == 24'(DEBOUNCE_CYC))
    else $error("qualified before debounce time");
  a_debounce_restart: assert property (@(posedge clk) disable iff (sys_rst) // R16
    !lineActive |=> dbCnt_q == 24'h000000 && !qualified_q)
    else $error("debounce not restarted");
  a_one_trigger: assert property (@(posedge clk) disable iff (sys_rst) // R4
    trigger |=> !trigger[*8])
    else $error("repeated trigger on one activation");
  a_enable_gate: assert property (@(posedge clk) disable iff (sys_rst) // R17
    drvEnable |-> $past(extMode) && $past(motion.windingsPowered))
    else $error("driver enable outside driver mode");
  a_step_spacing: assert property (@(posedge clk) disable iff (sys_rst) // R13
    stepAccept |=> !stepAccept[*7])
    else $error("step rate too high");
  a_pin_takeover: assert property (@(posedge clk) disable iff (sys_rst) // R14
    $past(extMode) |-> ioLineOe && ioLineOut == $past(stepOut_q))
    else $error("pin not given to step clock");
  a_out_event: assert property (@(posedge clk) disable iff (sys_rst) // R9
    $past(isOut && !extMode) |-> ioLineOut == $past(eventLevel ^ cfg_q[CFG_INVERT]))
    else $error("output line not following event");
  a_dir_follow: assert property (@(posedge clk) disable iff (sys_rst) // R11
    stepAccept |=> ##1 drvDirection == $past(stepDirRight, 2))
    else $error("direction not following request");
  a_step_period: assert property (@(posedge clk) disable iff (sys_rst) // R13
    stepAccept |-> sinceStep_q >= 8'(STEP_MIN_CYC))
    else $error("step period below minimum");
  a_cmd_cause: assert property (@(posedge clk) disable iff (sys_rst) // R4
    |actionCmd |-> $past(trigger))
    else $error("action without qualified trigger");
  a_alarm_entry: assert property (@(posedge clk) disable iff (sys_rst) // R5
    $rose(alarm_q) |-> $past(trigger && act == ACT_ALARM))
    else $error("alarm entered without alarm action");
  a_drv_off: assert property (@(posedge clk) disable iff (sys_rst) // R17
    !extMode |=> !drvEnable)
    else $error("driver enable left on");
  a_pin_release: assert property (@(posedge clk) disable iff (sys_rst) // R1
    $past(!extMode && !isOut) |-> !ioLineOe)
    else $error("pin driven in input mode");
endmodule

// ### testbench/mxio_ext_model.sv
`timescale 1ns/100ps
module mxio_ext_model
(
  // pin side
  input wire logic ioLineOut,
  input wire logic ioLineOe,
  input wire logic swClosed,
  output logic ioLineIn,
  // pulses seen by the driver
  output int pulses
);
  // weak pull-down: an open switch reads low
  assign ioLineIn = ioLineOe ? ioLineOut : swClosed;
  initial pulses = 0;
  // one displacement per pulse, same division as the controller
  always @(posedge ioLineOut)
    if (ioLineOe)
      pulses++;
endmodule

// ### testbench/motor_aux_io_and_step_dir_out_tb.sv
`timescale 1ns/100ps
module motor_aux_io_and_step_dir_out_tb;
  import mxio_pkg::*;
  logic clk = 0, sys_rst = 1, reinit = 0, stepReq = 0, stepDirRight = 0, swClosed = 0;
  mxio_bus_req_t busReq = '0;
  mxio_motion_t motion = '0;
  logic [31:0] busRdata;
  logic irq, stepAccept, alarmActive, bridgeEnable, ioLineIn, ioLineOut, ioLineOe;
  logic drvEnable, drvDirection;
  mxio_cmd_t actionCmd;
  int pulses, err_total = 0, compares = 0;
  always #50 clk = ~clk;
  mxio_aux_io dut(.clk(clk), .sys_rst(sys_rst), .busReq(busReq), .busRdata(busRdata),
    .irq(irq), .motion(motion), .reinit(reinit), .stepReq(stepReq),
    .stepDirRight(stepDirRight), .stepAccept(stepAccept), .actionCmd(actionCmd),
    .alarmActive(alarmActive), .bridgeEnable(bridgeEnable), .ioLineIn(ioLineIn),
    .ioLineOut(ioLineOut), .ioLineOe(ioLineOe), .drvEnable(drvEnable),
    .drvDirection(drvDirection));
  mxio_ext_model ext(.ioLineOut(ioLineOut), .ioLineOe(ioLineOe), .swClosed(swClosed),
    .ioLineIn(ioLineIn), .pulses(pulses));
  task automatic results();
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    @(posedge clk);
    busReq.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] exp, string nm);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clk);
    busReq.rd <= 1'b0;
    @(negedge clk);
    chk(nm, exp, busRdata);
    @(posedge clk);
  endtask
  // waits for bit sel of {alarmActive, actionCmd}; returns cycles spent,
  // at the falling edge where the bit stands so one-cycle pulses can be checked
  task automatic waitSig(int sel, output int n);
    logic [4:0] seen;
    for (n = 0; n < DEBOUNCE_CYC + 100; n++)
    begin
      @(negedge clk);
      seen = {alarmActive, actionCmd};
      if (seen[sel] === 1'b1)
        break;
    end
    if (n >= DEBOUNCE_CYC + 100)
    begin
      err_total++;
      results();
    end
  endtask
  task automatic t_reset();
    chk("bridgeEnable", 1, bridgeEnable);
    chk("irq", 0, irq);
    rd(REG_CFG, 0, "cfg");
    rd(REG_STATUS, 0, "status");
    rd(4'hF, 0, "unmapped");
  endtask
  task automatic t_trigger();
    int n;
    wr(REG_IRQ_MASK, 32'h3);
    wr(REG_CFG, 32'h100 | (ACT_STOP << CFG_ACT_LSB));
    swClosed <= 1'b1;
    repeat (1000) @(posedge clk);
    swClosed <= 1'b0;
    repeat (20) @(posedge clk);
    swClosed <= 1'b1;
    waitSig(3, n);
    chk("delay", 1, n >= DEBOUNCE_CYC && n <= DEBOUNCE_CYC + 8);
    chk("cmd", 4'h8, actionCmd);
    chk("irq", 1, irq);
    @(posedge clk);
    rd(REG_STATUS, 32'h1, "status");
    chk("irq", 1, irq);
    wr(REG_IRQ_STAT, 32'h1);
    @(negedge clk);
    chk("irq", 0, irq);
    @(posedge clk);
  endtask
  task automatic t_alarm();
    int n;
    swClosed <= 1'b0;
    wr(REG_CFG, 32'h100 | (ACT_ALARM << CFG_ACT_LSB));
    repeat (10) @(posedge clk);
    wr(REG_CFG, 32'h102 | (ACT_ALARM << CFG_ACT_LSB));
    waitSig(4, n);
    chk("delay", 1, n >= DEBOUNCE_CYC && n <= DEBOUNCE_CYC + 8);
    repeat (50) @(posedge clk);
    @(negedge clk);
    chk("bridgeEnable", 0, bridgeEnable);
    chk("alarm", 1, alarmActive);
    @(posedge clk);
    rd(REG_STATUS, 32'h3, "status");
    rd(REG_IRQ_STAT, 32'h3, "irqStat");
    wr(REG_CFG, 32'h1 | (OSEL_ALARM << CFG_OSEL_LSB));
    @(negedge clk);
    chk("out", 1, ioLineOut);
    @(posedge clk);
    reinit <= 1'b1;
    @(posedge clk);
    reinit <= 1'b0;
    repeat (2) @(negedge clk);
    chk("alarm", 0, alarmActive);
    chk("bridgeEnable", 1, bridgeEnable);
    chk("out", 0, ioLineOut);
    @(posedge clk);
  endtask
  task automatic t_output();
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 3; j++)
      begin
        motion <= 3'h4 >> j;
        wr(REG_CFG, 32'h1 | (i << CFG_OSEL_LSB));
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("oe", 1, ioLineOe);
        chk("out", (i == 0 && j == 0) || (i == 2 && j == 1) || (i == 3 && j == 2),
          ioLineOut);
        @(posedge clk);
      end
  endtask
  task automatic t_step(logic dir);
    int acc = 0, gap = STEP_MIN_CYC, p0;
    motion <= 3'b010;
    wr(REG_CFG, 32'h80);
    p0 = pulses;
    stepDirRight <= dir;
    stepReq <= 1'b1;
    repeat (400)
    begin
      @(negedge clk);
      gap++;
      if (stepAccept === 1'b1)
      begin
        chk("gap", 1, gap >= STEP_MIN_CYC);
        gap = 0;
        acc++;
      end
    end
    @(posedge clk);
    stepReq <= 1'b0;
    repeat (200) @(posedge clk);
    @(negedge clk);
    chk("accepts", (400 + STEP_MIN_CYC - 1) / STEP_MIN_CYC, acc);
    chk("pulses", acc, pulses - p0);
    chk("oe", 1, ioLineOe);
    chk("dir", dir, drvDirection);
    chk("enable", 1, drvEnable);
    @(posedge clk);
    wr(REG_CFG, 32'h0);
    repeat (3) @(negedge clk);
    chk("enable", 0, drvEnable);
    @(posedge clk);
  endtask
  // line already active across a reset must still fire the selected action
  task automatic t_powerup();
    int n;
    swClosed <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("irq", 0, irq);
    chk("enable", 0, drvEnable);
    rd(REG_CFG, 0, "cfg");
    wr(REG_CFG, 32'h100 | (ACT_HOME << CFG_ACT_LSB));
    waitSig(0, n);
    chk("cmd", 4'h1, actionCmd);
    chk("alarm", 0, alarmActive);
    @(posedge clk);
    rd(REG_IRQ_STAT, 32'h1, "irqStat");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_trigger();
    t_alarm();
    t_output();
    t_step(1'b1);
    t_step(1'b0);
    t_powerup();
    results();
  end
endmodule
